// >>> pkg/pxr_params.svh
// constants of the phy extended control register bank
`ifndef PXR_PARAMS_SVH
`define PXR_PARAMS_SVH

`define PXR_PREAMBLE_BITS 6'h20
`define PXR_OP_READ 2'h2
`define PXR_OP_WRITE 2'h1
`define PXR_ADDR_LAST 4'h9
`define PXR_DATA_LAST 4'hF

`define PXR_REG_CTRL0 5'h00
`define PXR_REG_ECS 5'h16
`define PXR_REG_EPC1 5'h17
`define PXR_REG_EPC2 5'h18
`define PXR_SOFT_RST_BIT 15

`define PXR_ECS_FORCE 15
`define PXR_ECS_JABBER 14
`define PXR_ECS_ECHO 13
`define PXR_ECS_SQE 12
`define PXR_ECS_SQL 11:10
`define PXR_ECS_SRE 9
`define PXR_ECS_BCAST 0
`define PXR_EPC1_MODE 13:11
`define PXR_EPC1_FEL 3
`define PXR_EPC2_EDGE 15:13
`define PXR_EPC2_RPWR 12
`define PXR_EPC2_JUMBO 5:4
`define PXR_EPC2_CLB 0

`define PXR_RST_FORCE 1'b0
`define PXR_RST_JABBER 1'b0
`define PXR_RST_ECHO 1'b1
`define PXR_RST_SQE 1'b1
`define PXR_RST_SQL 2'h0
`define PXR_RST_SRE 1'b1
`define PXR_RST_BCAST 1'b0
`define PXR_RST_EPC1_MODE 3'h2
`define PXR_RST_FEL 1'b0
`define PXR_RST_EDGE 3'h0
`define PXR_RST_RPWR 1'b0
`define PXR_RST_JUMBO 2'h0
`define PXR_RST_CLB 1'b0

`define PXR_PKT_STD 16'h0600
`define PXR_PKT_9K 16'h2400
`define PXR_PKT_12K 16'h3000
`define PXR_PKT_16K 16'h4000

`endif

// >>> pkg/pxr_pkg.sv
// types of the phy extended control register bank
package pxr_pkg;
    typedef enum logic [2:0] {S_PRE, S_START, S_OP, S_ADDR, S_TA, S_DATA} pxr_state_e;
    typedef enum logic [1:0] {
        MAC_GMII = 2'h0,
        MAC_RMII = 2'h1,
        MAC_RGMII = 2'h2,
        MAC_RSVD = 2'h3
    } pxr_mac_if_e;
    typedef enum logic [1:0] {
        JUMBO_STD = 2'h0,
        JUMBO_9K = 2'h1,
        JUMBO_12K = 2'h2,
        JUMBO_RSVD = 2'h3
    } pxr_jumbo_e;
    typedef logic [4:0] pxr_addr_t;
    typedef logic [15:0] pxr_word_t;
endpackage : pxr_pkg

// >>> pkg/pxr_acc_if.sv
// register access strobes from the management frame engine to the register cells
`timescale 1ns/1ps
interface pxr_acc_if;
    import pxr_pkg::*;
    logic wr_pulse;
    logic rd_pulse;
    pxr_addr_t reg_addr;
    pxr_word_t wdata;
    modport drive (output wr_pulse, output rd_pulse, output reg_addr, output wdata);
    modport sink (input wr_pulse, input rd_pulse, input reg_addr, input wdata);
endinterface : pxr_acc_if

// >>> hdl/pxr_sc_flag.sv
// self-clearing status flag that holds until read or software reset
`timescale 1ns/1ps
`include "pxr_params.svh"
module pxr_sc_flag
    import pxr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    pxr_acc_if.sink acc,
    input wire logic rd_sel,
    input wire logic soft_rst,
    input wire logic event_in,
    output logic flag
);
    logic read_clear;

    assign read_clear = acc.rd_pulse && rd_sel && (acc.reg_addr == `PXR_REG_ECS);

    // an event in the clearing cycle wins, so it is seen on the next read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (event_in) begin
            flag <= 1'b1;
        end else if (soft_rst || read_clear) begin
            flag <= 1'b0;
        end
    end
endmodule : pxr_sc_flag

// >>> hdl/pxr_mode_pend.sv
// pending and active copies of the clock source and interface mode bits
`timescale 1ns/1ps
`include "pxr_params.svh"
module pxr_mode_pend
    import pxr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    pxr_acc_if.sink acc,
    input wire logic wr_sel,
    input wire logic apply,
    output logic [2:0] active
);
    logic [2:0] pending;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pending <= `PXR_RST_EPC1_MODE;
        end else if (acc.wr_pulse && wr_sel && acc.reg_addr == `PXR_REG_EPC1) begin
            pending <= acc.wdata[`PXR_EPC1_MODE];
        end
    end

    // the running mode only moves at a software reset or while held in low power
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            active <= `PXR_RST_EPC1_MODE;
        end else if (apply) begin
            active <= pending;
        end
    end
endmodule : pxr_mode_pend

// >>> hdl/pxr_ext_regs.sv
// phy extended control registers with their serial management frame engine
`timescale 1ns/1ps
`include "pxr_params.svh"
module pxr_ext_regs
    import pxr_pkg::*;
#(
    parameter int NUM_PHY = 4,
    parameter logic [4:0] PHY_BASE = 5'h00
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic low_power_hold_mode,
    input wire logic ref_clock_tight_ppm,
    input wire logic [NUM_PHY-1:0] link_raw,
    input wire logic [NUM_PHY-1:0] eof_error_evt,
    input wire logic [NUM_PHY-1:0] link_disc_evt,
    output logic [NUM_PHY-1:0] soft_reset,
    output logic [NUM_PHY-1:0] link_pass,
    output logic [NUM_PHY-1:0] force_link,
    output logic [NUM_PHY-1:0] jabber_disable,
    output logic [NUM_PHY-1:0] echo_disable,
    output logic [NUM_PHY-1:0] sqe_disable,
    output logic [NUM_PHY-1:0][1:0] squelch_level,
    output logic [NUM_PHY-1:0] sticky_rst_en,
    output logic [NUM_PHY-1:0] bcast_write,
    output logic [NUM_PHY-1:0][1:0] mac_if_mode,
    output logic [NUM_PHY-1:0] rx_clk_from_ref,
    output logic [NUM_PHY-1:0] far_end_loopback,
    output logic [NUM_PHY-1:0][2:0] edge_rate,
    output logic [NUM_PHY-1:0] reduced_power,
    output logic [NUM_PHY-1:0][1:0] jumbo_mode,
    output logic [NUM_PHY-1:0][15:0] max_pkt_len,
    output logic [NUM_PHY-1:0] connector_loopback
);
    pxr_acc_if acc ();

    pxr_state_e state;
    logic mdc_d;
    logic mdc_rise;
    logic [5:0] pre_cnt;
    logic [3:0] bit_cnt;
    logic op_first;
    logic is_read;
    logic [8:0] addr_sh;
    logic [4:0] frame_phy;
    logic [4:0] phy_off;
    logic in_range;
    logic bcast_on;
    logic [15:0] data_sh;
    logic [15:0] rd_word;
    logic [NUM_PHY-1:0] wr_sel;
    logic [NUM_PHY-1:0] rd_sel;
    logic [NUM_PHY-1:0] ecs_wr;
    logic [NUM_PHY-1:0] epc1_wr;
    logic [NUM_PHY-1:0] epc2_wr;
    logic [NUM_PHY-1:0] eof_flag;
    logic [NUM_PHY-1:0] disc_flag;
    logic [NUM_PHY-1:0][2:0] epc1_active;

    // the management clock is sampled as a plain input; only its rising edge matters
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mdc_d <= 1'b0;
        end else begin
            mdc_d <= mdc;
        end
    end

    assign mdc_rise = mdc && !mdc_d;

    // frame sequencer: preamble, start, opcode, addresses, turnaround, data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= S_PRE;
            pre_cnt <= 6'h00;
            bit_cnt <= 4'h0;
            op_first <= 1'b0;
            is_read <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state)
                S_PRE: begin
                    if (mdio_in) begin
                        if (pre_cnt != `PXR_PREAMBLE_BITS) begin
                            pre_cnt <= pre_cnt + 6'h01;
                        end
                    end else begin
                        pre_cnt <= 6'h00;
                        if (pre_cnt == `PXR_PREAMBLE_BITS) begin
                            state <= S_START;
                        end
                    end
                end
                S_START: begin
                    bit_cnt <= 4'h0;
                    state <= mdio_in ? S_OP : S_PRE;
                end
                S_OP: begin
                    op_first <= mdio_in;
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == 4'h1) begin
                        bit_cnt <= 4'h0;
                        is_read <= ({op_first, mdio_in} == `PXR_OP_READ);
                        if ({op_first, mdio_in} == `PXR_OP_READ
                            || {op_first, mdio_in} == `PXR_OP_WRITE) begin
                            state <= S_ADDR;
                        end else begin
                            state <= S_PRE;
                        end
                    end
                end
                S_ADDR: begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == `PXR_ADDR_LAST) begin
                        bit_cnt <= 4'h0;
                        state <= S_TA;
                    end
                end
                S_TA: begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == 4'h1) begin
                        bit_cnt <= 4'h0;
                        state <= S_DATA;
                    end
                end
                S_DATA: begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == `PXR_DATA_LAST) begin
                        bit_cnt <= 4'h0;
                        state <= S_PRE;
                    end
                end
                default: begin
                    state <= S_PRE;
                end
            endcase
        end
    end

    // phy and register address; held until the next frame reaches its address
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addr_sh <= 9'h000;
            frame_phy <= 5'h00;
            acc.reg_addr <= 5'h00;
        end else if (mdc_rise && state == S_ADDR) begin
            addr_sh <= {addr_sh[7:0], mdio_in};
            if (bit_cnt == `PXR_ADDR_LAST) begin
                frame_phy <= addr_sh[8:4];
                acc.reg_addr <= {addr_sh[3:0], mdio_in};
            end
        end
    end

    assign phy_off = frame_phy - PHY_BASE;
    assign in_range = ({27'h0000000, phy_off} < 32'(NUM_PHY));

    // a write reaches every phy whose address matches, or all while the addressed phy has broadcast on
    always_comb begin
        bcast_on = 1'b0;
        for (int i = 0; i < NUM_PHY; i++) begin
            if (phy_off == 5'(i)) begin
                bcast_on = bcast_write[i];
            end
        end
        for (int i = 0; i < NUM_PHY; i++) begin
            wr_sel[i] = in_range && (bcast_on || phy_off == 5'(i));
            rd_sel[i] = in_range && (phy_off == 5'(i));
            ecs_wr[i] = acc.wr_pulse && wr_sel[i] && acc.reg_addr == `PXR_REG_ECS;
            epc1_wr[i] = acc.wr_pulse && wr_sel[i] && acc.reg_addr == `PXR_REG_EPC1;
            epc2_wr[i] = acc.wr_pulse && wr_sel[i] && acc.reg_addr == `PXR_REG_EPC2;
        end
    end

    // read strobe comes in the turnaround so the snapshot and the clear share one cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc.rd_pulse <= 1'b0;
            acc.wr_pulse <= 1'b0;
            acc.wdata <= 16'h0000;
        end else begin
            acc.rd_pulse <= mdc_rise && state == S_TA && bit_cnt == 4'h0
                && is_read && in_range;
            acc.wr_pulse <= mdc_rise && state == S_DATA && bit_cnt == `PXR_DATA_LAST
                && !is_read;
            if (mdc_rise && state == S_DATA && bit_cnt == `PXR_DATA_LAST) begin
                acc.wdata <= {data_sh[14:0], mdio_in};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_sh <= 16'h0000;
        end else if (acc.rd_pulse) begin
            data_sh <= rd_word;
        end else if (mdc_rise) begin
            if (state == S_TA && bit_cnt == 4'h1 && is_read) begin
                data_sh <= {data_sh[14:0], 1'b0};
            end else if (state == S_DATA) begin
                data_sh <= {data_sh[14:0], is_read ? 1'b0 : mdio_in};
            end
        end
    end

    // the pin changes just after a rising edge so the controller samples it stable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
        end else if (mdc_rise) begin
            if (state == S_TA && is_read && in_range) begin
                mdio_oe <= 1'b1;
                mdio_out <= (bit_cnt == 4'h0) ? 1'b0 : data_sh[15];
            end else if (state == S_DATA && mdio_oe && bit_cnt != `PXR_DATA_LAST) begin
                mdio_out <= data_sh[15];
            end else begin
                mdio_oe <= 1'b0;
                mdio_out <= 1'b0;
            end
        end
    end

    // only the addressed phy answers; unknown registers and reserved bits read zero
    always_comb begin
        rd_word = 16'h0000;
        for (int i = 0; i < NUM_PHY; i++) begin
            if (rd_sel[i] && acc.reg_addr == `PXR_REG_ECS) begin
                rd_word = {force_link[i], jabber_disable[i], echo_disable[i],
                    sqe_disable[i], squelch_level[i], sticky_rst_en[i], eof_flag[i],
                    disc_flag[i], link_pass[i], 5'h00, bcast_write[i]};
            end else if (rd_sel[i] && acc.reg_addr == `PXR_REG_EPC1) begin
                rd_word = {2'h0, epc1_active[i], 7'h00, far_end_loopback[i], 3'h0};
            end else if (rd_sel[i] && acc.reg_addr == `PXR_REG_EPC2) begin
                rd_word = {edge_rate[i], reduced_power[i], 6'h00, jumbo_mode[i], 3'h0,
                    connector_loopback[i]};
            end
        end
    end

    // a mode write takes hold at this reset, or while low_power_hold_mode is high
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NUM_PHY; i++) begin
            if (rst) begin
                soft_reset[i] <= 1'b0;
            end else begin
                soft_reset[i] <= acc.wr_pulse && wr_sel[i]
                    && acc.reg_addr == `PXR_REG_CTRL0
                    && acc.wdata[`PXR_SOFT_RST_BIT];
            end
        end
    end

    // sticky fields of the extended control and status register
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NUM_PHY; i++) begin
            if (rst || (soft_reset[i] && !sticky_rst_en[i])) begin
                force_link[i] <= `PXR_RST_FORCE;
                jabber_disable[i] <= `PXR_RST_JABBER;
                echo_disable[i] <= `PXR_RST_ECHO;
                sqe_disable[i] <= `PXR_RST_SQE;
                squelch_level[i] <= `PXR_RST_SQL;
                bcast_write[i] <= `PXR_RST_BCAST;
            end else if (ecs_wr[i]) begin
                force_link[i] <= acc.wdata[`PXR_ECS_FORCE];
                jabber_disable[i] <= acc.wdata[`PXR_ECS_JABBER];
                echo_disable[i] <= acc.wdata[`PXR_ECS_ECHO];
                sqe_disable[i] <= acc.wdata[`PXR_ECS_SQE];
                squelch_level[i] <= acc.wdata[`PXR_ECS_SQL];
                bcast_write[i] <= acc.wdata[`PXR_ECS_BCAST];
            end
        end
    end

    // the enable itself ignores software reset
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NUM_PHY; i++) begin
            if (rst) begin
                sticky_rst_en[i] <= `PXR_RST_SRE;
            end else if (ecs_wr[i]) begin
                sticky_rst_en[i] <= acc.wdata[`PXR_ECS_SRE];
            end
        end
    end

    // loopback controls are not sticky and always return to default
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NUM_PHY; i++) begin
            if (rst || soft_reset[i]) begin
                far_end_loopback[i] <= `PXR_RST_FEL;
                connector_loopback[i] <= `PXR_RST_CLB;
            end else begin
                if (epc1_wr[i]) begin
                    far_end_loopback[i] <= acc.wdata[`PXR_EPC1_FEL];
                end
                if (epc2_wr[i]) begin
                    connector_loopback[i] <= acc.wdata[`PXR_EPC2_CLB];
                end
            end
        end
    end

    // sticky fields of ext_phy_control_two
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NUM_PHY; i++) begin
            if (rst || (soft_reset[i] && !sticky_rst_en[i])) begin
                edge_rate[i] <= `PXR_RST_EDGE;
                reduced_power[i] <= `PXR_RST_RPWR;
                jumbo_mode[i] <= `PXR_RST_JUMBO;
            end else if (epc2_wr[i]) begin
                edge_rate[i] <= acc.wdata[`PXR_EPC2_EDGE];
                reduced_power[i] <= acc.wdata[`PXR_EPC2_RPWR];
                jumbo_mode[i] <= acc.wdata[`PXR_EPC2_JUMBO];
            end
        end
    end

    // derived link, clock and packet length controls
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NUM_PHY; i++) begin
            if (rst) begin
                link_pass[i] <= 1'b0;
                rx_clk_from_ref[i] <= 1'b0;
                max_pkt_len[i] <= `PXR_PKT_STD;
            end else begin
                link_pass[i] <= force_link[i] || link_raw[i];
                rx_clk_from_ref[i] <= epc1_active[i][2]
                    && epc1_active[i][1:0] != MAC_RMII;
                unique case (pxr_jumbo_e'(jumbo_mode[i]))
                    JUMBO_9K: begin
                        max_pkt_len[i] <= ref_clock_tight_ppm ? `PXR_PKT_12K
                            : `PXR_PKT_9K;
                    end
                    JUMBO_12K: begin
                        max_pkt_len[i] <= ref_clock_tight_ppm ? `PXR_PKT_16K
                            : `PXR_PKT_12K;
                    end
                    // reserved code behaves as the standard length
                    JUMBO_STD, JUMBO_RSVD: begin
                        max_pkt_len[i] <= `PXR_PKT_STD;
                    end
                endcase
            end
        end
    end

    for (genvar g = 0; g < NUM_PHY; g++) begin : g_phy
        pxr_sc_flag u_eof (
            .clk_sys(clk_sys),
            .rst(rst),
            .acc(acc),
            .rd_sel(rd_sel[g]),
            .soft_rst(soft_reset[g]),
            .event_in(eof_error_evt[g]),
            .flag(eof_flag[g])
        );

        pxr_sc_flag u_disc (
            .clk_sys(clk_sys),
            .rst(rst),
            .acc(acc),
            .rd_sel(rd_sel[g]),
            .soft_rst(soft_reset[g]),
            .event_in(link_disc_evt[g]),
            .flag(disc_flag[g])
        );

        pxr_mode_pend u_mode (
            .clk_sys(clk_sys),
            .rst(rst),
            .acc(acc),
            .wr_sel(wr_sel[g]),
            .apply(soft_reset[g] || low_power_hold_mode),
            .active(epc1_active[g])
        );

        assign mac_if_mode[g] = epc1_active[g][1:0];
    end
endmodule : pxr_ext_regs

// >>> tb/pxr_ext_regs_asserts.sv
// pin-level assertions for the extended control register bank
`timescale 1ns/1ps
module pxr_ext_regs_asserts
    import pxr_pkg::*;
#(
    parameter int NUM_PHY = 4
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic ref_clock_tight_ppm,
    input wire logic [NUM_PHY-1:0] link_raw,
    input wire logic [NUM_PHY-1:0] soft_reset,
    input wire logic [NUM_PHY-1:0] link_pass,
    input wire logic [NUM_PHY-1:0] force_link,
    input wire logic [NUM_PHY-1:0] echo_disable,
    input wire logic [NUM_PHY-1:0] sqe_disable,
    input wire logic [NUM_PHY-1:0] sticky_rst_en,
    input wire logic [NUM_PHY-1:0][1:0] mac_if_mode,
    input wire logic [NUM_PHY-1:0] rx_clk_from_ref,
    input wire logic [NUM_PHY-1:0][1:0] jumbo_mode,
    input wire logic [NUM_PHY-1:0][15:0] max_pkt_len
);
    logic [15:0] exp_len;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_comb begin
        case (jumbo_mode[0])
            2'h1: exp_len = ref_clock_tight_ppm ? 16'h3000 : 16'h2400;
            2'h2: exp_len = ref_clock_tight_ppm ? 16'h4000 : 16'h3000;
            default: exp_len = 16'h0600;
        endcase
    end
    link_follow_a: assert property (
        !$past(rst) |-> link_pass == $past(force_link | link_raw))
        else $error("link pass not following its inputs");
    // phy 1 is one of the two phys, with phy 2, whose force bit a scenario sets
    force_pass_a: assert property (force_link[1] |=> link_pass[1])
        else $error("forced link not reported as pass");
    reset_default_a: assert property (
        $fell(rst) |-> echo_disable == '1 && sqe_disable == '1 && sticky_rst_en == '1
        && mac_if_mode[0] == MAC_RGMII)
        else $error("wrong defaults after reset");
    super_sticky_a: assert property (|soft_reset |=> $stable(sticky_rst_en))
        else $error("sticky enable moved on software reset");
    sticky_clear_a: assert property (
        soft_reset[1] && !sticky_rst_en[1] |-> ##[0:2] !force_link[1])
        else $error("sticky bit kept with sticky enable clear");
    rmii_clock_a: assert property (
        rx_clk_from_ref[0] |-> $past(mac_if_mode[0]) != MAC_RMII)
        else $error("reference receive clock in reduced mode");
    pkt_len_a: assert property (
        $stable(jumbo_mode[0]) && $stable(ref_clock_tight_ppm) |-> max_pkt_len[0] == exp_len)
        else $error("maximum packet length wrong");
    turn_start_a: assert property (
        $rose(mdio_oe) |-> !mdio_out && $past(mdc) && !$past(mdc, 2))
        else $error("turnaround drive misplaced");
    out_edge_a: assert property (
        mdio_oe && $changed(mdio_out) |-> $past(mdc) && !$past(mdc, 2))
        else $error("read data changed off the clock edge");
endmodule : pxr_ext_regs_asserts

bind pxr_ext_regs pxr_ext_regs_asserts #(.NUM_PHY(NUM_PHY)) u_pxr_ext_regs_asserts (.*);

// >>> tb/pxr_smi_master.sv
// station management controller model on the serial management pins
`timescale 1ns/1ps
module pxr_smi_master (
    input wire logic clk_sys,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output logic mdc,
    output logic mdio_in
);
    logic drv_en = 1'h0;
    logic drv = 1'h1;
    // a released line floats high through the pull-up
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'h1);
    initial mdc = 1'h0;
    // two clocks low, two high; sample where the device samples
    task automatic shift(input logic en, input logic b, output logic got);
        @(posedge clk_sys);
        mdc <= 1'h0;
        drv_en <= en;
        drv <= b;
        @(posedge clk_sys);
        @(posedge clk_sys);
        mdc <= 1'h1;
        @(posedge clk_sys);
        got = mdio_in;
    endtask : shift
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rdv);
        logic [13:0] hdr;
        logic g;
        hdr = {2'h1, rd ? 2'h2 : 2'h1, phy, rg};
        for (int i = 0; i < 32; i++) shift(1'h1, 1'h1, g);
        for (int i = 13; i >= 0; i--) shift(1'h1, hdr[i], g);
        // a read lets go of the line for the whole turnaround and data field
        shift(!rd, 1'h1, g);
        shift(!rd, 1'h0, g);
        for (int i = 15; i >= 0; i--) begin
            shift(!rd, wd[i], g);
            rdv[i] = g;
        end
        @(posedge clk_sys);
        drv_en <= 1'h0;
    endtask : frame
endmodule : pxr_smi_master

// >>> tb/pxr_ext_regs_bench.sv
// self-checking bench for the extended control register bank
`timescale 1ns/1ps
module pxr_ext_regs_bench;
    import pxr_pkg::*;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic mdc;
    logic mdio_in;
    logic mdio_out;
    logic mdio_oe;
    logic low_power_hold_mode = 1'h0;
    logic ref_clock_tight_ppm = 1'h0;
    logic [3:0] link_raw = 4'h0;
    logic [3:0] eof_error_evt = 4'h0;
    logic [3:0] link_disc_evt = 4'h0;
    logic [3:0] jabber_disable;
    logic [3:0] rx_clk_from_ref;
    logic [3:0][1:0] squelch_level;
    logic [3:0][1:0] mac_if_mode;
    logic [3:0][15:0] max_pkt_len;
    int fail_count = 0;
    int n_compared = 0;
    always #12.5 clk_sys = ~clk_sys;
    pxr_ext_regs u_pxr_ext_regs (
        .clk_sys, .rst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .low_power_hold_mode,
        .ref_clock_tight_ppm, .link_raw, .eof_error_evt, .link_disc_evt, .soft_reset(),
        .link_pass(), .force_link(), .jabber_disable, .echo_disable(), .sqe_disable(),
        .squelch_level, .sticky_rst_en(), .bcast_write(), .mac_if_mode, .rx_clk_from_ref,
        .far_end_loopback(), .edge_rate(), .reduced_power(), .jumbo_mode(), .max_pkt_len,
        .connector_loopback()
    );
    pxr_smi_master u_pxr_smi_master (.clk_sys, .mdio_out, .mdio_oe, .mdc, .mdio_in);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] wd);
        logic [15:0] d;
        u_pxr_smi_master.frame(1'h0, p, r, wd, d);
        repeat (4) @(posedge clk_sys);
    endtask : wr
    task automatic rdchk(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
        logic [15:0] d;
        u_pxr_smi_master.frame(1'h1, p, r, 16'h0000, d);
        check(d, e);
    endtask : rdchk
    task automatic t_reset();
        rdchk(5'h00, 5'h16, 16'h3200);
        rdchk(5'h00, 5'h17, 16'h1000);
        rdchk(5'h00, 5'h18, 16'h0000);
        rdchk(5'h00, 5'h10, 16'h0000);
        rdchk(5'h05, 5'h16, 16'hFFFF);
        $display("test reset done");
    endtask : t_reset
    task automatic t_ctrl();
        wr(5'h01, 5'h16, 16'hF400);
        rdchk(5'h01, 5'h16, 16'hF440);
        check({15'h0000, jabber_disable[1]}, 16'h0001);
        check({14'h0000, squelch_level[1]}, 16'h0001);
        rdchk(5'h00, 5'h16, 16'h3200);
        wr(5'h01, 5'h00, 16'h8000);
        rdchk(5'h01, 5'h16, 16'h3000);
        wr(5'h02, 5'h16, 16'hFA00);
        wr(5'h02, 5'h00, 16'h8000);
        rdchk(5'h02, 5'h16, 16'hFA40);
        $display("test ctrl done");
    endtask : t_ctrl
    task automatic t_status();
        @(posedge clk_sys);
        link_raw <= 4'h1;
        eof_error_evt <= 4'h1;
        link_disc_evt <= 4'h1;
        @(posedge clk_sys);
        eof_error_evt <= 4'h0;
        link_disc_evt <= 4'h0;
        rdchk(5'h00, 5'h16, 16'h33C0);
        rdchk(5'h00, 5'h16, 16'h3240);
        $display("test status done");
    endtask : t_status
    task automatic t_mode();
        wr(5'h00, 5'h17, 16'h2800);
        rdchk(5'h00, 5'h17, 16'h1000);
        wr(5'h00, 5'h00, 16'h8000);
        rdchk(5'h00, 5'h17, 16'h2800);
        check({14'h0000, mac_if_mode[0]}, 16'h0001);
        check({15'h0000, rx_clk_from_ref[0]}, 16'h0000);
        wr(5'h00, 5'h17, 16'h2000);
        low_power_hold_mode <= 1'h1;
        repeat (3) @(posedge clk_sys);
        low_power_hold_mode <= 1'h0;
        rdchk(5'h00, 5'h17, 16'h2000);
        check({15'h0000, rx_clk_from_ref[0]}, 16'h0001);
        $display("test mode done");
    endtask : t_mode
    task automatic t_bcast();
        wr(5'h03, 5'h16, 16'h3201);
        wr(5'h03, 5'h18, 16'h1020);
        rdchk(5'h00, 5'h18, 16'h1020);
        rdchk(5'h00, 5'h16, 16'h3240);
        check(max_pkt_len[0], 16'h3000);
        ref_clock_tight_ppm <= 1'h1;
        repeat (3) @(posedge clk_sys);
        check(max_pkt_len[0], 16'h4000);
        ref_clock_tight_ppm <= 1'h0;
        wr(5'h03, 5'h16, 16'h3200);
        wr(5'h03, 5'h18, 16'h0010);
        rdchk(5'h00, 5'h18, 16'h1020);
        check(max_pkt_len[3], 16'h2400);
        $display("test bcast done");
    endtask : t_bcast
    task automatic t_rsvd();
        wr(5'h02, 5'h18, 16'hFFFF);
        rdchk(5'h02, 5'h18, 16'hF031);
        check(max_pkt_len[2], 16'h0600);
        wr(5'h02, 5'h17, 16'hFFFF);
        rdchk(5'h02, 5'h17, 16'h1008);
        $display("test rsvd done");
    endtask : t_rsvd
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        t_reset();
        t_ctrl();
        t_status();
        t_mode();
        t_bcast();
        t_rsvd();
        close_out();
    end
    // the whole run needs about eight thousand clocks
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        close_out();
    end
endmodule : pxr_ext_regs_bench
